// ---- rtl/fsi_pkg.sv ----
// Purpose: Shared constants and types for the fieldbus status indicator block
// Assumes: 40 MHz system clock
// Notes:   Flash rates derived from fixed prescalers
package fsi_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned FAST_FLASH_MHZ  = 10_000;   // Fast flash in mHz (10 Hz)
    localparam int unsigned SLOW_FLASH_MHZ  = 2_500;    // Slow flash in mHz (2.5 Hz)
    // Half period in cycles, toggled at 50 percent duty
    // Divide before scaling, so a fractional rate in Hz is kept and nothing overflows
    localparam int unsigned FAST_HALF_CYC   = (CLK_HZ / 2) / FAST_FLASH_MHZ * 1000;
    localparam int unsigned SLOW_HALF_CYC   = (CLK_HZ / 2) / SLOW_FLASH_MHZ * 1000;
    localparam int unsigned MIN_SYNC_US     = 500;
    localparam int unsigned MIN_SYNC_CYC    = (CLK_HZ / 1_000_000) * MIN_SYNC_US;
    localparam int unsigned ACT_HOLD_CYC    = 2_000_000;  // Activity flash stretch, 50 ms
    localparam int unsigned SYNC_PERIOD_W   = 24;

    // ****************************************************************
    // Slave state encoding on the state input
    // ****************************************************************
    localparam logic [1:0] SST_INIT   = 2'h0;
    localparam logic [1:0] SST_PREOP  = 2'h1;
    localparam logic [1:0] SST_SAFEOP = 2'h2;
    localparam logic [1:0] SST_OP     = 2'h3;

    typedef enum logic [1:0] {
        FSI_HLTH_OK,
        FSI_HLTH_NODE_TO,
        FSI_HLTH_PSU_TO,
        FSI_HLTH_CARD_FAIL
    } fsi_health_t;

endpackage

// ---- rtl/fsi_flash_if.sv ----
// Purpose: Carries the flash pattern levels between modules
// Assumes: Single clock domain
// Notes:   Levels only, no handshake
`timescale 1ns/1ps
interface fsi_flash_if;
    logic fast_lvl;
    logic slow_lvl;
    modport src (output fast_lvl, output slow_lvl);
    modport dst (input fast_lvl, input slow_lvl);
endinterface

// ---- rtl/fsi_flash_gen.sv ----
// Purpose: Fast and slow 50 percent flash level generator
// Assumes: Parameters give half periods in clock cycles
// Notes:   Both levels start low after reset
`timescale 1ns/1ps
module fsi_flash_gen
    import fsi_pkg::*;
#(
    parameter int unsigned FAST_HALF = FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC
) (
    input  wire logic  clk_sys,
    input  wire logic  sys_rst,
    fsi_flash_if.src   flash
);
    localparam int CW = $clog2(SLOW_HALF + 1);

    logic [CW-1:0] fast_cnt_reg, fast_cnt_next;
    logic [CW-1:0] slow_cnt_reg, slow_cnt_next;
    logic          fast_reg, fast_next;
    logic          slow_reg, slow_next;

    always_comb begin
        fast_cnt_next = fast_cnt_reg + 1'b1;
        slow_cnt_next = slow_cnt_reg + 1'b1;
        fast_next     = fast_reg;
        slow_next     = slow_reg;
        if (fast_cnt_reg == CW'(FAST_HALF - 1)) begin // R10
            fast_cnt_next = '0;
            fast_next     = ~fast_reg;
        end
        if (slow_cnt_reg == CW'(SLOW_HALF - 1)) begin // R10
            slow_cnt_next = '0;
            slow_next     = ~slow_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fast_cnt_reg <= '0;
            slow_cnt_reg <= '0;
            fast_reg     <= 1'b0;
            slow_reg     <= 1'b0;
        end else begin
            fast_cnt_reg <= fast_cnt_next;
            slow_cnt_reg <= slow_cnt_next;
            fast_reg     <= fast_next;
            slow_reg     <= slow_next;
        end
    end

    assign flash.fast_lvl  = fast_reg;
    assign flash.slow_lvl  = slow_reg;
endmodule

// ---- rtl/fsi_status_indicator.sv ----
// What this block does
// [R1] Accept sync periods of 500 us or longer
// [R2] Health green steady when all normal
// [R3] Health red steady on node timeout
// [R4] Health red slow flash on supply timeout
// [R5] Health red fast flash on card failure
// [R6] State green follows INIT PREOP SAFEOP OP
// [R7] Fault red steady while bus fault present
// [R8] Link yellow on while upstream connected
// [R9] Link green flashes during port traffic
// [R10] Fixed prescalers give fast and slow rates
// [R11] Health shows most severe present condition
//
// Purpose: Drive the four status indicators of the fieldbus card
// Assumes: All condition inputs synchronous to clk_sys
// Notes:   Every indicator output is registered
`timescale 1ns/1ps
module fsi_status_indicator
    import fsi_pkg::*;
#(
    parameter int unsigned FAST_HALF = FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned ACT_HOLD  = ACT_HOLD_CYC
) (
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire logic                     card_fail,
    input  wire logic                     psu_timeout,
    input  wire logic                     node_timeout,
    input  wire logic [1:0]               slave_state,
    input  wire logic                     bus_fault,
    input  wire logic                     upstream_port_linked,
    input  wire logic                     port_traffic,
    input  wire logic [SYNC_PERIOD_W-1:0] sync_period_cyc,
    input  wire logic                     sync_enabled,
    output logic                          health_green,
    output logic                          health_red,
    output logic                          slave_state_indicator,
    output logic                          bus_fault_indicator,
    output logic                          link_activity_yellow,
    output logic                          link_activity_green,
    output logic                          sync_period_bad
);

    // ****************************************************************
    // Flash rate source
    // ****************************************************************
    // One divider for all indicators keeps their flashing in phase
    fsi_flash_if flash ();

    fsi_flash_gen #(
        .FAST_HALF (FAST_HALF),
        .SLOW_HALF (SLOW_HALF)
    ) u_flash (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .flash   (flash)
    );

    // ****************************************************************
    // Pattern decoding
    // ****************************************************************
    typedef enum logic [1:0] {
        FSI_PAT_OFF,
        FSI_PAT_FAST,
        FSI_PAT_SLOW,
        FSI_PAT_STEADY
    } fsi_pattern_t;

    // Shared decode, so health and state show the same rates
    function automatic logic pattern_level(
        input fsi_pattern_t pat,
        input logic         fast_lvl,
        input logic         slow_lvl
    );
        logic lvl;
        lvl = 1'b0;
        unique case (pat)
            FSI_PAT_OFF:    lvl = 1'b0;
            FSI_PAT_FAST:   lvl = fast_lvl;
            FSI_PAT_SLOW:   lvl = slow_lvl;
            FSI_PAT_STEADY: lvl = 1'b1;
        endcase
        return lvl;
    endfunction

    // ****************************************************************
    // Health priority
    // ****************************************************************
    function automatic fsi_health_t pick_health(input logic fail, input logic psu, input logic node);
        if (fail)
            return FSI_HLTH_CARD_FAIL;
        else if (psu)
            return FSI_HLTH_PSU_TO;
        else if (node)
            return FSI_HLTH_NODE_TO;
        else
            return FSI_HLTH_OK;
    endfunction

    fsi_health_t  health_sel;
    fsi_pattern_t red_pat;
    logic         hg_reg, hg_next;
    logic         hr_reg, hr_next;

    assign health_sel = pick_health(card_fail, psu_timeout, node_timeout); // R11

    // Green only with no alarm, so both elements never light together
    always_comb begin
        hg_next = 1'b0;
        red_pat = FSI_PAT_OFF;
        unique case (health_sel)
            FSI_HLTH_OK:        hg_next = 1'b1;            // R2
            FSI_HLTH_NODE_TO:   red_pat = FSI_PAT_STEADY;  // R3
            FSI_HLTH_PSU_TO:    red_pat = FSI_PAT_SLOW;    // R4
            FSI_HLTH_CARD_FAIL: red_pat = FSI_PAT_FAST;    // R5
        endcase
        hr_next = pattern_level(red_pat, flash.fast_lvl, flash.slow_lvl);
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hg_reg <= 1'b0;
            hr_reg <= 1'b0;
        end else begin
            hg_reg <= hg_next;
            hr_reg <= hr_next;
        end
    end

    // ****************************************************************
    // Slave state
    // ****************************************************************
    fsi_pattern_t state_pat;
    logic         ss_reg, ss_next;

    always_comb begin
        state_pat = FSI_PAT_OFF;
        unique case (slave_state)                          // R6
            SST_INIT:   state_pat = FSI_PAT_OFF;
            SST_PREOP:  state_pat = FSI_PAT_FAST;
            SST_SAFEOP: state_pat = FSI_PAT_SLOW;
            SST_OP:     state_pat = FSI_PAT_STEADY;
        endcase
        ss_next = pattern_level(state_pat, flash.fast_lvl, flash.slow_lvl);
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ss_reg <= 1'b0;
        end else begin
            ss_reg <= ss_next;
        end
    end

    // ****************************************************************
    // Bus fault
    // ****************************************************************
    logic bf_reg, bf_next;

    always_comb begin
        bf_next = bus_fault;                               // R7
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bf_reg <= 1'b0;
        end else begin
            bf_reg <= bf_next;
        end
    end

    // ****************************************************************
    // Link and activity
    // ****************************************************************
    // Short bursts of traffic would be invisible, so activity is held
    localparam int AW = $clog2(ACT_HOLD + 1);
    logic [AW-1:0] act_cnt_reg, act_cnt_next;
    logic          ly_reg, ly_next;
    logic          lg_reg, lg_next;

    always_comb begin
        act_cnt_next = act_cnt_reg;
        if (port_traffic)
            act_cnt_next = AW'(ACT_HOLD);
        else if (act_cnt_reg != '0)
            act_cnt_next = act_cnt_reg - 1'b1;
        ly_next = upstream_port_linked;                    // R8
        lg_next = (act_cnt_reg != '0) && flash.fast_lvl;   // R9
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            act_cnt_reg <= '0;
            ly_reg      <= 1'b0;
            lg_reg      <= 1'b0;
        end else begin
            act_cnt_reg <= act_cnt_next;
            ly_reg      <= ly_next;
            lg_reg      <= lg_next;
        end
    end

    // ****************************************************************
    // Sync period check
    // ****************************************************************
    // Only a lower bound is checked; any longer period is accepted
    logic sp_reg, sp_next;

    always_comb begin
        sp_next = sync_enabled && (sync_period_cyc < SYNC_PERIOD_W'(MIN_SYNC_CYC)); // R1
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sp_reg <= 1'b0;
        end else begin
            sp_reg <= sp_next;
        end
    end

    // ****************************************************************
    // Outputs, all straight from flip-flops
    // ****************************************************************
    assign health_green          = hg_reg;
    assign health_red            = hr_reg;
    assign slave_state_indicator = ss_reg;
    assign bus_fault_indicator   = bf_reg;
    assign link_activity_yellow  = ly_reg;
    assign link_activity_green   = lg_reg;
    assign sync_period_bad       = sp_reg;
endmodule

// ---- verif/fsi_master_model.sv ----
// Purpose: Master station side that drives slave state, link and traffic
// Assumes: Same clock as the indicator block
// Notes:   Registered, so every command lands one cycle late
`timescale 1ns/1ps
module fsi_master_model
    import fsi_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       link_up,
    input  wire logic [1:0] go_state,
    input  wire logic       send,
    output logic            upstream_port_linked,
    output logic [1:0]      slave_state,
    output logic            port_traffic
);
    // Without a cable the slave falls back to init
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            {upstream_port_linked, slave_state, port_traffic} <= 4'h0;
        end else begin
            upstream_port_linked <= link_up;
            slave_state          <= link_up ? go_state : SST_INIT;
            port_traffic         <= link_up & send;
        end
    end
endmodule

// ---- verif/fsi_status_chk.sv ----
// Purpose: Assertions on the indicator outputs
// Assumes: Outputs lag their inputs by one cycle
// Notes:   Flash rates are judged by the bench
`timescale 1ns/1ps
module fsi_status_chk
    import fsi_pkg::*;
#(
    parameter int unsigned ACT_HOLD = ACT_HOLD_CYC
) (
    input wire logic                     clk_sys,
    input wire logic                     sys_rst,
    input wire logic                     card_fail,
    input wire logic                     psu_timeout,
    input wire logic                     node_timeout,
    input wire logic [1:0]               slave_state,
    input wire logic                     bus_fault,
    input wire logic                     port_traffic,
    input wire logic                     upstream_port_linked,
    input wire logic [SYNC_PERIOD_W-1:0] sync_period_cyc,
    input wire logic                     sync_enabled,
    input wire logic                     health_green,
    input wire logic                     health_red,
    input wire logic                     slave_state_indicator,
    input wire logic                     bus_fault_indicator,
    input wire logic                     link_activity_yellow,
    input wire logic                     link_activity_green,
    input wire logic                     sync_period_bad
);
    // Guards $past against values from inside reset
    logic        live_reg;
    int unsigned idle_reg, idle_next;
    always_comb idle_next = port_traffic ? 0 : (idle_reg < 1000 ? idle_reg + 1 : idle_reg);
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            live_reg <= 1'b0;
            idle_reg <= 0;
        end else begin
            live_reg <= 1'b1;
            idle_reg <= idle_next;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_GREEN: assert property (live_reg && $past(!card_fail && !psu_timeout && !node_timeout) |-> health_green)
        else $error("health not green");
    AST_NODE: assert property ((node_timeout && !psu_timeout && !card_fail) [*2] |=> health_red && !health_green)
        else $error("node timeout not steady red");
    AST_ALARM: assert property (live_reg && $past(card_fail || psu_timeout) |-> !health_green)
        else $error("green during alarm");
    AST_INIT: assert property (live_reg && $past(slave_state) == SST_INIT |-> !slave_state_indicator)
        else $error("state lit in init");
    AST_OP: assert property (live_reg && $past(slave_state) == SST_OP |-> slave_state_indicator)
        else $error("state dark in op");
    AST_FAULT: assert property (live_reg |-> bus_fault_indicator == $past(bus_fault))
        else $error("fault indicator wrong");
    AST_LINK: assert property (live_reg |-> link_activity_yellow == $past(upstream_port_linked))
        else $error("link indicator wrong");
    AST_QUIET: assert property (idle_reg > ACT_HOLD + 2 |-> !link_activity_green)
        else $error("activity lit while quiet");
    AST_SYNC: assert property (live_reg |-> sync_period_bad == $past(sync_enabled && sync_period_cyc < MIN_SYNC_CYC))
        else $error("sync period flag wrong");
endmodule
bind fsi_status_indicator fsi_status_chk #(.ACT_HOLD(ACT_HOLD)) u_fsi_status_chk (
    .clk_sys               (clk_sys),
    .sys_rst               (sys_rst),
    .card_fail             (card_fail),
    .psu_timeout           (psu_timeout),
    .node_timeout          (node_timeout),
    .slave_state           (slave_state),
    .bus_fault             (bus_fault),
    .port_traffic          (port_traffic),
    .upstream_port_linked  (upstream_port_linked),
    .sync_period_cyc       (sync_period_cyc),
    .sync_enabled          (sync_enabled),
    .health_green          (health_green),
    .health_red            (health_red),
    .slave_state_indicator (slave_state_indicator),
    .bus_fault_indicator   (bus_fault_indicator),
    .link_activity_yellow  (link_activity_yellow),
    .link_activity_green   (link_activity_green),
    .sync_period_bad       (sync_period_bad)
);

// ---- verif/fsi_status_indicator_test.sv ----
// Purpose: Self-checking bench for the status indicator block
// Assumes: Short prescalers so flash periods are countable
// Notes:   Half periods are measured in whole clock cycles
`timescale 1ns/1ps
module fsi_status_indicator_test;
    import fsi_pkg::*;
    localparam int FH = 4, SH = 16, AH = 40;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, card_fail = 1'b0, psu_timeout = 1'b0, node_timeout = 1'b0;
    logic        bus_fault = 1'b0, sync_enabled = 1'b0, link_up = 1'b0, send = 1'b0;
    logic [1:0]  go_state = 2'h0, slave_state;
    logic [23:0] sync_period_cyc = 24'h0;
    logic        upstream_port_linked, port_traffic, health_green, health_red, slave_state_indicator;
    logic        bus_fault_indicator, link_activity_yellow, link_activity_green, sync_period_bad;
    int          bad_count = 0, checks_done = 0;
    always #12.5 clk_sys = ~clk_sys;
    fsi_status_indicator #(.FAST_HALF(FH), .SLOW_HALF(SH), .ACT_HOLD(AH)) u_fsi_status_indicator (
        .clk_sys               (clk_sys),
        .sys_rst               (sys_rst),
        .card_fail             (card_fail),
        .psu_timeout           (psu_timeout),
        .node_timeout          (node_timeout),
        .slave_state           (slave_state),
        .bus_fault             (bus_fault),
        .upstream_port_linked  (upstream_port_linked),
        .port_traffic          (port_traffic),
        .sync_period_cyc       (sync_period_cyc),
        .sync_enabled          (sync_enabled),
        .health_green          (health_green),
        .health_red            (health_red),
        .slave_state_indicator (slave_state_indicator),
        .bus_fault_indicator   (bus_fault_indicator),
        .link_activity_yellow  (link_activity_yellow),
        .link_activity_green   (link_activity_green),
        .sync_period_bad       (sync_period_bad)
    );
    fsi_master_model u_fsi_master_model (
        .clk_sys              (clk_sys),
        .sys_rst              (sys_rst),
        .link_up              (link_up),
        .go_state             (go_state),
        .send                 (send),
        .upstream_port_linked (upstream_port_linked),
        .slave_state          (slave_state),
        .port_traffic         (port_traffic)
    );
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            bad_count++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? health_red : (s == 1 ? slave_state_indicator : link_activity_green);
    endfunction
    // Skip a partial first phase before counting
    task automatic half(input int s, input int exp);
        int n;
        n = 0;
        // Let the new input reach the output before phases are judged
        wt(3);
        for (int i = 0; i < 200 && pick(s) !== 1'b0; i++) wt(1);
        for (int i = 0; i < 200 && pick(s) !== 1'b1; i++) wt(1);
        while (pick(s) === 1'b1 && n < 200) begin
            wt(1);
            n++;
        end
        chk_cnt(n, exp);
    endtask
    task automatic t_health();
        chk_cnt(FAST_HALF_CYC, 2_000_000);
        chk_cnt(SLOW_HALF_CYC, 8_000_000);
        chk_bit(health_green, 1'b1);
        @(posedge clk_sys) node_timeout <= 1'b1;
        wt(3);
        chk_bit(health_red, 1'b1);
        @(posedge clk_sys) psu_timeout <= 1'b1;
        half(0, SH);
        @(posedge clk_sys) card_fail <= 1'b1;
        half(0, FH);
        @(posedge clk_sys) {card_fail, psu_timeout, node_timeout} <= 3'h0;
        wt(3);
        chk_bit(health_red, 1'b0);
    endtask
    task automatic t_fault();
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk_sys) bus_fault <= v[0];
            wt(3);
            chk_bit(bus_fault_indicator, v[0]);
        end
    endtask
    task automatic t_state_link();
        @(posedge clk_sys) {link_up, go_state} <= {1'b1, SST_OP};
        wt(4);
        chk_bit(slave_state_indicator, 1'b1);
        chk_bit(link_activity_yellow, 1'b1);
        @(posedge clk_sys) go_state <= SST_PREOP;
        half(1, FH);
        @(posedge clk_sys) go_state <= SST_SAFEOP;
        half(1, SH);
        @(posedge clk_sys) send <= 1'b1;
        half(2, FH);
        @(posedge clk_sys) {send, link_up} <= 2'h0;
        wt(AH + 8);
        chk_bit(link_activity_green, 1'b0);
        chk_bit(link_activity_yellow, 1'b0);
        chk_bit(slave_state_indicator, 1'b0);
    endtask
    task automatic t_sync();
        @(posedge clk_sys) {sync_enabled, sync_period_cyc} <= {1'b1, 24'(MIN_SYNC_CYC - 1)};
        wt(3);
        chk_bit(sync_period_bad, 1'b1);
        @(posedge clk_sys) sync_period_cyc <= 24'(MIN_SYNC_CYC);
        wt(3);
        chk_bit(sync_period_bad, 1'b0);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wt(3);
        t_health();
        t_fault();
        t_state_link();
        t_sync();
        give_verdict();
    end
    initial begin
        #500000;
        bad_count++;
        give_verdict();
    end
endmodule
